// ===== scrc_engine.v
// Serial 16-bit CRC engine with programmable polynomial and seed, AHB-Lite register slave
// Functional notes
// [RULE1] A seed write also loads the shift register so computation starts from it.
// [RULE2] Software clears enable, writes seed, then restores the enable bit.
// [RULE3] Software disables, writes the 16-bit polynomial, then restores enable.
// [RULE4] CCITT needs polynomial 0x8810, lowest term dropped.
// [RULE5] CCITT needs seed 0xFFFF programmed before enabling.
// [RULE6] Full 16-bit CRC readable through high and low shift bytes.
// [RULE7] Reading a shift byte overwrites the seed with the current CRC.
// [RULE8] Software must not read the result while bits are still shifting in.
// [RULE9] Low control bit 0 enables computation; all other control bits read zero.
// [RULE10] Low input select: upper nibble picks data source, lower picks clock.
// [RULE11] High input select lower nibble picks clock; both bytes share it.
// [RULE12] Shift register is high byte over low byte.
// [RULE13] Polynomial is high byte over low byte, both writable.
// [RULE14] Seed is high byte over low byte, both writable.
// [RULE15] When enabled, one bit shifts in MSB first per selected clock rising edge. The code shifts only while the high clock select matches the low one.
// [RULE16] Seed write while enabled leaves the shift register unchanged.
// [RULE17] Polynomial holds coefficients of powers 16 down to 1; unity implied. The code takes powers 15 down to 0 with x^16 implied.
// [RULE18] Galois step: XOR polynomial in when top bit XOR input is one.
`timescale 1ns/1ps
`default_nettype none
`include "scrc_regs.vh"

module scrc_engine (
   // Clock and reset
   input wire CORE_CLK,
   input wire RST_N,
   // AHB-Lite slave
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   // Serial sources and clock sources, asynchronous pins
   input wire [15:0] DATA_SRC,
   input wire [15:0] CLK_SRC,
   // Running CRC and enable state
   output reg [15:0] CRC_OUT,
   output reg CRC_ENABLED
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   reg [7:0] lo_insel_q;
   reg [3:0] hi_clksel_q;
   reg en_q;
   reg [15:0] poly_q;
   reg [15:0] seed_q;
   reg [15:0] shift_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: two flops before any selection or edge detection
   reg [15:0] dsrc_m_q;
   reg [15:0] dsrc_s_q;
   reg [15:0] csrc_m_q;
   reg [15:0] csrc_s_q;
   reg [15:0] csrc_p_q;

   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dsrc_m_q <= `SCRC_RST_WORD;
         dsrc_s_q <= `SCRC_RST_WORD;
         csrc_m_q <= `SCRC_RST_WORD;
         csrc_s_q <= `SCRC_RST_WORD;
         csrc_p_q <= `SCRC_RST_WORD;
      end else begin
         dsrc_m_q <= DATA_SRC;
         dsrc_s_q <= dsrc_m_q;
         csrc_m_q <= CLK_SRC;
         csrc_s_q <= csrc_m_q;
         csrc_p_q <= csrc_s_q;
      end
   end

   // Rising edge of every clock source, one enable pulse each
   wire [15:0] clk_rise;
   genvar gi;
   generate
      for (gi = 0; gi < `SCRC_NSEL; gi = gi + 1) begin : g_edge
         assign clk_rise[gi] = csrc_s_q[gi] & ~csrc_p_q[gi];
      end
   endgenerate

   // Both byte halves must run on one clock; a mismatched high selection stalls
   // the engine rather than tearing the register into two time bases.
   wire [3:0] lo_clksel = lo_insel_q[`SCRC_CLK_MSB:`SCRC_CLK_LSB];
   wire [3:0] data_sel = lo_insel_q[`SCRC_SRC_MSB:`SCRC_SRC_LSB];
   wire shift_tick = clk_rise[lo_clksel] & (hi_clksel_q == lo_clksel); // see [RULE10] [RULE11]
   wire din = dsrc_s_q[data_sel]; // see [RULE10]

   // Galois step; poly bit 15 is x^15 coefficient position, x^16 implied, bit 0 is x^0
   wire fb = shift_q[15] ^ din; // see [RULE18]
   wire [15:0] shifted = {shift_q[14:0], 1'b0};
   wire [15:0] crc_next = fb ? (shifted ^ poly_q) : shifted; // see [RULE17] [RULE18]

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture; zero wait states
   reg dph_q;
   reg dph_wr_q;
   reg [`SCRC_AW-1:0] dph_addr_q;

   wire take = HSEL & HREADY & (HTRANS == `SCRC_HTRANS_NONSEQ);

   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dph_q <= 1'b0;
         dph_wr_q <= 1'b0;
         dph_addr_q <= {`SCRC_AW{1'b0}};
      end else if (HREADY) begin
         dph_q <= take;
         dph_wr_q <= HWRITE;
         dph_addr_q <= HADDR[`SCRC_AW-1:0];
      end
   end

   wire wr = dph_q & dph_wr_q;
   wire [7:0] wb = HWDATA[7:0];
   // Shift byte read is decoded in the address phase so the seed copy is one edge
   wire rd_shift = take & ~HWRITE &
                   ((HADDR[`SCRC_AW-1:0] == `SCRC_A_SHIFT_HI) |
                    (HADDR[`SCRC_AW-1:0] == `SCRC_A_SHIFT_LO));
   wire wr_seed_hi = wr & (dph_addr_q == `SCRC_A_SEED_HI);
   wire wr_seed_lo = wr & (dph_addr_q == `SCRC_A_SEED_LO);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lo_insel_q <= `SCRC_RST_BYTE;
         hi_clksel_q <= 4'h0;
         en_q <= 1'b0;
         poly_q <= `SCRC_RST_WORD;
      end else if (wr) begin
         case (dph_addr_q)
            `SCRC_A_LO_INSEL: lo_insel_q <= wb;
            `SCRC_A_HI_INSEL: hi_clksel_q <= wb[`SCRC_CLK_MSB:`SCRC_CLK_LSB]; // see [RULE11]
            `SCRC_A_LO_CTRL: en_q <= wb[`SCRC_EN_BIT]; // see [RULE9]
            `SCRC_A_POLY_HI: poly_q[15:8] <= wb; // see [RULE13]
            `SCRC_A_POLY_LO: poly_q[7:0] <= wb; // see [RULE13]
            default: en_q <= en_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Seed and shift registers
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         seed_q <= `SCRC_RST_WORD;
      end else if (wr_seed_hi) begin
         seed_q[15:8] <= wb; // see [RULE14]
      end else if (wr_seed_lo) begin
         seed_q[7:0] <= wb; // see [RULE14]
      end else if (rd_shift) begin
         seed_q <= shift_q; // see [RULE7]
      end
   end

   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         shift_q <= `SCRC_RST_WORD;
      end else if (!en_q) begin
         // Stopped: seed bytes latch through, a started engine ignores them
         if (wr_seed_hi) begin
            shift_q[15:8] <= wb; // see [RULE1] [RULE16] [RULE12]
         end else if (wr_seed_lo) begin
            shift_q[7:0] <= wb; // see [RULE1] [RULE16] [RULE12]
         end
      end else if (shift_tick) begin
         shift_q <= crc_next; // see [RULE15]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data and status outputs
   // Read data is registered at the address phase so HRDATA comes from a flop
   reg [7:0] rd_next;
   always @* begin
      case (HADDR[`SCRC_AW-1:0])
         `SCRC_A_HI_FUNC: rd_next = `SCRC_HI_FUNC_VAL;
         `SCRC_A_LO_FUNC: rd_next = `SCRC_LO_FUNC_VAL;
         `SCRC_A_HI_INSEL: rd_next = {`SCRC_HI_INSEL_FIX, hi_clksel_q};
         `SCRC_A_LO_INSEL: rd_next = lo_insel_q;
         `SCRC_A_SHIFT_HI: rd_next = shift_q[15:8]; // see [RULE6] [RULE12]
         `SCRC_A_SHIFT_LO: rd_next = shift_q[7:0]; // see [RULE6] [RULE12]
         `SCRC_A_POLY_HI: rd_next = poly_q[15:8];
         `SCRC_A_POLY_LO: rd_next = poly_q[7:0];
         `SCRC_A_SEED_HI: rd_next = seed_q[15:8];
         `SCRC_A_SEED_LO: rd_next = seed_q[7:0];
         `SCRC_A_LO_CTRL: rd_next = {7'h00, en_q}; // see [RULE9]
         default: rd_next = `SCRC_RST_BYTE;
      endcase
   end

   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         HRDATA <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         CRC_OUT <= `SCRC_RST_WORD;
         CRC_ENABLED <= 1'b0;
      end else begin
         if (take && !HWRITE) begin
            HRDATA <= {24'h000000, rd_next};
         end
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         CRC_OUT <= shift_q;
         CRC_ENABLED <= en_q;
      end
   end

endmodule
`default_nettype wire

// ===== scrc_engine_sva.sv
// Port checks for the serial CRC engine
`timescale 1ns/1ps
`default_nettype none
module scrc_engine_sva (
   // Clock and reset
   input wire CORE_CLK,
   input wire RST_N,
   // Bus
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   input wire [31:0] HRDATA,
   input wire HREADYOUT,
   input wire HRESP,
   // Result
   input wire [15:0] CRC_OUT,
   input wire CRC_ENABLED
);
   wire tk = HSEL && HREADY && HTRANS == 2'b10;
   wire rd = tk && !HWRITE;
   wire [11:0] a = HADDR[11:0];
   reg wr_q;
   reg [11:0] ad_q;
   reg [7:0] dq_q;
   // Data-phase write data is kept so the checks can look a cycle or two later
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_q <= 1'b0;
         ad_q <= 12'h000;
         dq_q <= 8'h00;
      end else begin
         wr_q <= tk && HWRITE;
         ad_q <= a;
         dq_q <= wr_q ? HWDATA[7:0] : dq_q;
      end
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus wait or error");
   a_en_write: assert property (wr_q && ad_q == 12'h034 |-> ##[1:2] CRC_ENABLED == dq_q[0])
      else $error("enable bit not taken");
   a_seed_lo: assert property (wr_q && ad_q == 12'h02c && !CRC_ENABLED |-> ##[1:2] CRC_OUT[7:0] == dq_q)
      else $error("low seed not loaded");
   a_seed_hi: assert property (wr_q && ad_q == 12'h028 && !CRC_ENABLED |-> ##[1:2] CRC_OUT[15:8] == dq_q)
      else $error("high seed not loaded");
   a_idle_hold: assert property (!CRC_ENABLED && !$past(CRC_ENABLED) && !wr_q && !$past(wr_q) |=> $stable(CRC_OUT))
      else $error("shift moved while stopped");
   a_rd_shift_hi: assert property (rd && a == 12'h018 |=> HRDATA == {24'h0, CRC_OUT[15:8]})
      else $error("high shift read wrong");
   a_rd_shift_lo: assert property (rd && a == 12'h01c |=> HRDATA == {24'h0, CRC_OUT[7:0]})
      else $error("low shift read wrong");
   a_rd_zero: assert property (rd && (a == 12'h030 || a == 12'h014 || a == 12'h03c) |=> HRDATA == 32'h0)
      else $error("zero register read nonzero");
   c_start: cover property ($rose(CRC_ENABLED));
   c_shift: cover property (CRC_ENABLED && $changed(CRC_OUT));
   c_read: cover property (rd && a == 12'h018);
endmodule
bind scrc_engine scrc_engine_sva scrc_engine_sva_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
   .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .CRC_OUT(CRC_OUT), .CRC_ENABLED(CRC_ENABLED));
`default_nettype wire

// ===== scrc_engine_tb.sv
// Self-checking bench for the serial CRC engine
`timescale 1ns/1ps
`default_nettype none
module scrc_engine_tb;
   logic CORE_CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
   logic [1:0] HTRANS = 2'b00;
   wire [31:0] HRDATA;
   wire HREADYOUT, HRESP, CRC_ENABLED;
   wire [15:0] CRC_OUT, DATA_SRC, CLK_SRC;
   int n_mismatch = 0, cmp_count = 0;
   logic [31:0] rs = 32'd47;
   always #20 CORE_CLK = ~CORE_CLK;
   scrc_engine scrc_engine_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DATA_SRC(DATA_SRC),
      .CLK_SRC(CLK_SRC), .CRC_OUT(CRC_OUT), .CRC_ENABLED(CRC_ENABLED));
   scrc_src_model scrc_src_model_i (.clk(CORE_CLK), .clk_src(CLK_SRC), .data_src(DATA_SRC));
   function logic [15:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[15:0];
   endfunction
   function logic [15:0] crc(input logic [15:0] s, input logic [15:0] p, input logic [15:0] v);
      for (int i = 15; i >= 0; i--) s = {s[14:0], 1'b0} ^ ((s[15] ^ v[i]) ? p : 16'h0);
      return s;
   endfunction
   task test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task rdy;
      int i;
      i = 0;
      do begin
         @(posedge CORE_CLK);
         i++;
      end while (HREADYOUT !== 1'b1 && i < 64);
      if (HREADYOUT !== 1'b1) begin
         n_mismatch++;
         test_done;
      end
   endtask
   // Single unpipelined transfer: address phase, then data phase
   task xf(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HWRITE <= w;
      HADDR <= {20'h0, a};
      rdy;
      HTRANS <= 2'b00;
      HWDATA <= {24'h0, d};
      rdy;
      r = HRDATA;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      xf(1'b1, a, d, r);
   endtask
   task rc(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] r;
      xf(1'b0, a, 8'h00, r);
      cmp_count++;
      if (r !== {24'h0, e}) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, r, {24'h0, e});
      end
   endtask
   initial begin
      logic [15:0] p, s, v, x;
      logic [3:0] c, d, h;
      repeat (3) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      for (int a = 0; a <= 'h3c; a += 4) rc(a[11:0], a == 0 ? 8'h22 : a == 4 ? 8'h02 : a == 8 ? 8'h30 : 8'h00);
      for (int k = 0; k < 6; k++) begin
         p = k == 0 ? 16'h8810 : rnd();
         s = k == 0 ? 16'hffff : rnd();
         wr(12'h034, 8'h00);
         wr(12'h020, p[15:8]);
         wr(12'h024, p[7:0]);
         wr(12'h028, s[15:8]);
         wr(12'h02c, s[7:0]);
         rc(12'h024, p[7:0]);
         rc(12'h018, s[15:8]);
         x = rnd();
         c = x[3:0];
         d = x[7:4];
         h = k == 3 ? c + 4'h1 : c;
         wr(12'h00c, {d, c});
         wr(12'h008, {4'h0, h});
         rc(12'h00c, {d, c});
         rc(12'h008, {4'h3, h});
         wr(12'h034, 8'h01);
         rc(12'h034, 8'h01);
         if (k == 2) wr(12'h028, ~s[15:8]);
         v = rnd();
         scrc_src_model_i.send(c, d, v, 2 + k % 3);
         repeat (5) @(posedge CORE_CLK);
         wr(12'h034, 8'h00);
         x = k == 3 ? s : crc(s, p, v);
         rc(12'h018, x[15:8]);
         rc(12'h01c, x[7:0]);
         rc(12'h02c, x[7:0]);
         rc(12'h028, x[15:8]);
      end
      test_done;
   end
endmodule
`default_nettype wire

// ===== scrc_regs.vh
// Register map, field positions, reset values and mux sizes for the serial CRC engine
`ifndef SCRC_REGS_VH
`define SCRC_REGS_VH

// Byte addresses, one aligned word per byte-wide register
`define SCRC_A_HI_FUNC 12'h000
`define SCRC_A_LO_FUNC 12'h004
`define SCRC_A_HI_INSEL 12'h008
`define SCRC_A_LO_INSEL 12'h00c
`define SCRC_A_HI_OUTCFG 12'h010
`define SCRC_A_LO_OUTCFG 12'h014
`define SCRC_A_SHIFT_HI 12'h018
`define SCRC_A_SHIFT_LO 12'h01c
`define SCRC_A_POLY_HI 12'h020
`define SCRC_A_POLY_LO 12'h024
`define SCRC_A_SEED_HI 12'h028
`define SCRC_A_SEED_LO 12'h02c
`define SCRC_A_HI_CTRL 12'h030
`define SCRC_A_LO_CTRL 12'h034
`define SCRC_AW 12

// Fixed function configuration values
`define SCRC_HI_FUNC_VAL 8'h22
`define SCRC_LO_FUNC_VAL 8'h02
`define SCRC_HI_INSEL_FIX 4'h3

// Fields
`define SCRC_EN_BIT 0
`define SCRC_SRC_MSB 7
`define SCRC_SRC_LSB 4
`define SCRC_CLK_MSB 3
`define SCRC_CLK_LSB 0
`define SCRC_NSEL 16

// Reset values
`define SCRC_RST_BYTE 8'h00
`define SCRC_RST_WORD 16'h0000

// AHB encodings
`define SCRC_HTRANS_NONSEQ 2'b10
`define SCRC_HSIZE_WORD 3'b010

`endif

// ===== scrc_src_model.sv
// Serial data and shift clock source model
`timescale 1ns/1ps
`default_nettype none
module scrc_src_model (
   // Core clock
   input wire logic clk,
   // Source pins
   output logic [15:0] clk_src,
   output logic [15:0] data_src
);
   logic [15:0] nz = 16'hace1;
   logic [15:0] ck_q = 16'h0000;
   logic [15:0] dm_q = 16'h0000;
   logic [15:0] dv_q = 16'h0000;
   // Unused data lines churn every cycle so a stale value can never look right
   always @(posedge clk) nz <= {nz[14:0], nz[15] ^ nz[14] ^ nz[12] ^ nz[3]};
   assign data_src = (nz & ~dm_q) | (dv_q & dm_q);
   assign clk_src = ck_q;
   task send(input logic [3:0] c, input logic [3:0] d, input logic [15:0] v, input int hl);
      for (int i = 15; i >= 0; i--) begin
         dm_q <= 16'h0001 << d;
         dv_q <= {16{v[i]}};
         repeat (hl) @(posedge clk);
         ck_q <= 16'h0001 << c;
         repeat (hl) @(posedge clk);
         ck_q <= 16'h0000;
      end
      repeat (hl) @(posedge clk);
      dm_q <= 16'h0000;
   endtask
endmodule
`default_nettype wire
